/* lane_rx_pkg.sv */
/*
 File holds: shared constants, register map and carrier types of the serial lane receive link.
 Assumes: every user imports nothing and refers to names as lane_rx_pkg::name.
*/
package lane_rx_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [14:0] ADDR_IF_POWER = 15'h0200;
   localparam logic [14:0] ADDR_LANE_PD = 15'h0201;
   localparam logic [14:0] ADDR_LINK_MODE = 15'h0110;
   localparam logic [14:0] ADDR_CAL_START_A = 15'h02A7;
   localparam logic [14:0] ADDR_OVERRIDE_A = 15'h02A8;
   localparam logic [14:0] ADDR_CAL_CODE_A = 15'h02AC;
   localparam logic [14:0] ADDR_CAL_START_B = 15'h02AE;
   localparam logic [14:0] ADDR_OVERRIDE_B = 15'h02AF;
   localparam logic [14:0] ADDR_CAL_CODE_B = 15'h02B3;
   localparam logic [14:0] ADDR_OFFSET_FIRST = 15'h02BB;
   localparam logic [14:0] ADDR_OFFSET_LAST = 15'h02C2;
   // ****************************************************************
   // Fields and reset values
   // ****************************************************************
   localparam int IF_PD_BIT = 0;
   localparam int CAL_START_BIT = 0;
   localparam int OVR_EN_BIT = 4;
   localparam int OFS_SIGN_BIT = 3;
   localparam int DESCRAMBLE_BIT = 7;
   localparam logic [7:0] IF_POWER_RESET = 8'h01;
   localparam logic [7:0] LANE_PD_RESET = 8'hFF;
   localparam logic [7:0] LINK_MODE_RESET = 8'h08;
   localparam logic [7:0] GROUP_A_LANES = 8'hC3;
   localparam logic [3:0] CAL_CODE_DEFAULT = 4'h8;
   // ****************************************************************
   // Timing and lane rate bounds
   // ****************************************************************
   localparam int LANE_RATE_MIN_MBPS = 750;
   localparam int LANE_RATE_MAX_MBPS = 12500;
   localparam int CLK_MHZ = 50;
   localparam int CAL_TIME_NS = 2000;
   localparam int CAL_CYCLES = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int OCTETS_PER_PCLK = 4;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [14:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
   typedef struct packed {
      logic valid;
      logic [15:0] conv0;
      logic [15:0] conv1;
   } sample_type;
endpackage

/* term_cal_group.sv */
/*
 File holds: one termination autocalibration engine for a group of lanes.
 Assumes: start bit written by the register file, cal_target from the analog trim sense.
*/
`timescale 1ns/1ns
module term_cal_group
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start_bit,
   input wire logic [3:0] cal_target,
   output logic [3:0] cal_code,
   output logic busy
   );
   typedef struct packed {
      logic prev;
      logic busy;
      logic [7:0] count;
      logic [3:0] code;
   } cal_state_type;
   cal_state_type state;
   cal_state_type next_state;
   // Rising edge of start launches a fixed-length tune
   always_comb
   begin
      next_state = state;
      next_state.prev = start_bit;
      if (start_bit && !state.prev && !state.busy)
      begin
         next_state.busy = 1'b1;
         next_state.count = 8'(lane_rx_pkg::CAL_CYCLES);
      end
      else if (state.busy)
      begin
         next_state.count = state.count - 8'h01;
         if (state.count == 8'h01)
         begin
            next_state.busy = 1'b0;
            next_state.code = cal_target;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= '{prev: 1'b0, busy: 1'b0, count: 8'h00, code: lane_rx_pkg::CAL_CODE_DEFAULT};
      else
         state <= next_state;
   end
   assign cal_code = state.code;
   assign busy = state.busy;
   AST_CAL_DONE: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(busy) |-> busy [*8] ##[0:300] !busy) else $error("cal never ends");
endmodule // term_cal_group

/* lane_deframer.sv */
/*
 File holds: per-lane octet descrambler and the mode-driven transport mapping.
 Assumes: four octets per lane per processing cycle, lanes already aligned.
*/
`timescale 1ns/1ns
module lane_deframer
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] lane_count,
   input wire logic descramble_en,
   input wire logic in_valid,
   input wire logic [255:0] octets,
   output lane_rx_pkg::sample_type sample
   );
   typedef struct packed {
      logic [7:0][14:0] lfsr;
      lane_rx_pkg::sample_type out;
   } dfr_state_type;
   dfr_state_type state;
   dfr_state_type next_state;
   logic [7:0][31:0] plain;
   for (genvar g = 0; g < 8; g++)
   begin : g_lane
      always_comb
      begin
         logic [14:0] s;
         logic [31:0] w;
         s = state.lfsr[g];
         w = octets[g*32 +: 32];
         plain[g] = w;
         for (int b = 31; b >= 0; b--)
         begin
            plain[g][b] = descramble_en ? (w[b] ^ s[13] ^ s[14]) : w[b];
            s = {s[13:0], w[b]};
         end
      end
   end
   // octet of lane l, slot k: byte at word bits 31-8k
   function automatic logic [7:0] oct(input logic [7:0][31:0] p, input int l, input int k);
      oct = p[l][31-8*k -: 8];
   endfunction
   // Mapping by lane count, first sample of each converter per cycle
   always_comb
   begin
      next_state = state;
      next_state.out.valid = in_valid;
      for (int l = 0; l < 8; l++)
         next_state.lfsr[l] = in_valid ? octets[l*32 +: 15] : state.lfsr[l];
      case (lane_count)
         4'd1: next_state.out = '{in_valid, {oct(plain,0,0), oct(plain,0,1)},
                                  {oct(plain,0,2), oct(plain,0,3)}};
         4'd2: next_state.out = '{in_valid, {oct(plain,0,0), oct(plain,0,1)},
                                  {oct(plain,1,0), oct(plain,1,1)}};
         4'd3: next_state.out = '{in_valid, {oct(plain,0,0), oct(plain,0,1)},
                                  {oct(plain,1,2), oct(plain,1,3)}};
         4'd4: next_state.out = '{in_valid, {oct(plain,0,0), oct(plain,1,0)},
                                  {oct(plain,2,0), oct(plain,3,0)}};
         4'd6: next_state.out = '{in_valid, {oct(plain,0,0), oct(plain,0,1)},
                                  {oct(plain,3,0), oct(plain,3,1)}};
         4'd8: next_state.out = '{in_valid, {oct(plain,0,0), oct(plain,1,0)},
                                  {oct(plain,4,0), oct(plain,5,0)}};
         default: next_state.out.valid = 1'b0;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= '0;
      else
         state <= next_state;
   end
   assign sample = state.out;
   AST_MAP4: assert property (@(posedge clk) disable iff (!rst_n)
      (in_valid && lane_count == 4'd4 && !descramble_en) |=>
      sample.conv0 == {$past(octets[31:24]), $past(octets[63:56])}) else $error("map4 wrong");
endmodule // lane_deframer

/* serial_lane_rx_link_and_phy_control.sv */
/*
 File holds: top of the serial lane receive link with its register file and PHY control.
 Assumes: register port strobes come from the serial port decoder, one byte per strobe;
 lane words are already 8b/10b decoded into four octets per lane per clock.
*/
`timescale 1ns/1ns
module serial_lane_rx_link_and_phy_control
   #(
   parameter int LANES = 8
   )
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire lane_rx_pkg::reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [LANES*32-1:0] lane_octets,
   input wire logic [LANES-1:0] lane_sync_ok,
   input wire logic lane_valid,
   input wire logic [3:0] cal_target_a,
   input wire logic [3:0] cal_target_b,
   output logic link_sync_request_out,
   output logic [LANES-1:0] lane_power_on,
   output logic [LANES*4-1:0] lane_term_code,
   output lane_rx_pkg::sample_type sample,
   output logic [1:0] converter_count,
   output logic rate_error
   );
   // ****************************************************************
   // Parameter check
   // ****************************************************************
   // exactly eight lanes in one link
   if (LANES != 8)
   begin : g_bad_lanes
      $error("LANES must be 8");
   end
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [7:0] if_power;
      logic [7:0] lane_pd;
      logic [7:0] link_mode;
      logic [7:0] cal_start_a;
      logic [7:0] cal_start_b;
      logic [7:0] ovr_a;
      logic [7:0] ovr_b;
      logic [7:0][7:0] offset;
      logic [7:0] rdata;
      logic rvalid;
      logic sync_req;
      logic [7:0] power_on;
      logic [7:0][3:0] term;
      logic [1:0] conv;
      logic rate_err;
   } top_state_type;
   top_state_type state;
   top_state_type next_state;
   logic [3:0] code_a;
   logic [3:0] code_b;
   logic busy_a;
   logic busy_b;
   logic [3:0] lane_count;
   logic [255:0] gated_octets;
   logic [14:0] ofs_idx;
   // Low nibble of the mode register holds lane count, bit 7 the descramble enable
   assign lane_count = state.link_mode[3:0];
   assign ofs_idx = reg_req.addr - lane_rx_pkg::ADDR_OFFSET_FIRST;
   // ****************************************************************
   // Calibration engines
   // ****************************************************************
   // group A serves lanes 0,1,6,7
   term_cal_group u_cal_a
   (
      .clk(clk),
      .rst_n(rst_n),
      .start_bit(state.cal_start_a[lane_rx_pkg::CAL_START_BIT]),
      .cal_target(cal_target_a),
      .cal_code(code_a),
      .busy(busy_a)
   );
   // group B serves lanes 2 to 5
   term_cal_group u_cal_b
   (
      .clk(clk),
      .rst_n(rst_n),
      .start_bit(state.cal_start_b[lane_rx_pkg::CAL_START_BIT]),
      .cal_target(cal_target_b),
      .cal_code(code_b),
      .busy(busy_b)
   );
   // ****************************************************************
   // Lane data path
   // ****************************************************************
   // per channel data gated by power
   for (genvar g = 0; g < 8; g++)
   begin : g_gate
      assign gated_octets[g*32 +: 32] = state.power_on[g] ? lane_octets[g*32 +: 32] : 32'h0;
   end
   lane_deframer u_deframer
   (
      .clk(clk),
      .rst_n(rst_n),
      .lane_count(lane_count),
      .descramble_en(state.link_mode[lane_rx_pkg::DESCRAMBLE_BIT]),
      .in_valid(lane_valid && state.power_on != 8'h00),
      .octets(gated_octets),
      .sample(sample)
   );
   // ****************************************************************
   // Register file and control
   // ****************************************************************
   // Register writes, reads, termination codes and sync request
   always_comb
   begin
      logic [3:0] base;
      logic [3:0] ofs;
      logic [4:0] sum;
      logic [7:0] used;
      next_state = state;
      next_state.rvalid = 1'b0;
      base = 4'h0;
      ofs = 4'h0;
      sum = 5'h00;
      used = 8'h00;
      if (reg_req.wr)
      begin
         if (reg_req.addr == lane_rx_pkg::ADDR_LINK_MODE)
            next_state.link_mode = reg_req.wdata;
         else if (reg_req.addr == lane_rx_pkg::ADDR_IF_POWER)
            next_state.if_power = reg_req.wdata;
         else if (reg_req.addr == lane_rx_pkg::ADDR_LANE_PD)
            next_state.lane_pd = reg_req.wdata;
         else if (reg_req.addr == lane_rx_pkg::ADDR_CAL_START_A)
            next_state.cal_start_a = reg_req.wdata;
         else if (reg_req.addr == lane_rx_pkg::ADDR_CAL_START_B)
            next_state.cal_start_b = reg_req.wdata;
         else if (reg_req.addr == lane_rx_pkg::ADDR_OVERRIDE_A)
            next_state.ovr_a = reg_req.wdata;
         else if (reg_req.addr == lane_rx_pkg::ADDR_OVERRIDE_B)
            next_state.ovr_b = reg_req.wdata;
         else if (reg_req.addr >= lane_rx_pkg::ADDR_OFFSET_FIRST
                  && reg_req.addr <= lane_rx_pkg::ADDR_OFFSET_LAST)
            next_state.offset[ofs_idx[2:0]] = reg_req.wdata;
      end
      if (reg_req.rd)
      begin
         next_state.rvalid = 1'b1;
         if (reg_req.addr == lane_rx_pkg::ADDR_LINK_MODE)
            next_state.rdata = state.link_mode;
         else if (reg_req.addr == lane_rx_pkg::ADDR_IF_POWER)
            next_state.rdata = state.if_power;
         else if (reg_req.addr == lane_rx_pkg::ADDR_LANE_PD)
            next_state.rdata = state.lane_pd;
         else if (reg_req.addr == lane_rx_pkg::ADDR_CAL_START_A)
            next_state.rdata = state.cal_start_a;
         else if (reg_req.addr == lane_rx_pkg::ADDR_CAL_START_B)
            next_state.rdata = state.cal_start_b;
         else if (reg_req.addr == lane_rx_pkg::ADDR_OVERRIDE_A)
            next_state.rdata = state.ovr_a;
         else if (reg_req.addr == lane_rx_pkg::ADDR_OVERRIDE_B)
            next_state.rdata = state.ovr_b;
         else if (reg_req.addr == lane_rx_pkg::ADDR_CAL_CODE_A)
            next_state.rdata = {4'h0, code_a};
         else if (reg_req.addr == lane_rx_pkg::ADDR_CAL_CODE_B)
            next_state.rdata = {4'h0, code_b};
         else if (reg_req.addr >= lane_rx_pkg::ADDR_OFFSET_FIRST
                  && reg_req.addr <= lane_rx_pkg::ADDR_OFFSET_LAST)
            next_state.rdata = state.offset[ofs_idx[2:0]];
         else
            next_state.rdata = 8'h00; // Unmapped reads return zero
      end
      // powered down while bit zero set; per-lane mask
      next_state.power_on = state.if_power[lane_rx_pkg::IF_PD_BIT] ? 8'h00 : ~state.lane_pd;
      for (int l = 0; l < 8; l++)
      begin
         if (lane_rx_pkg::GROUP_A_LANES[l])
         begin
            // override replaces autocal, code itself kept
            base = state.ovr_a[lane_rx_pkg::OVR_EN_BIT] ? {1'b0, state.ovr_a[3:1]} : code_a;
         end
         else
         begin
            base = state.ovr_b[lane_rx_pkg::OVR_EN_BIT] ? {1'b0, state.ovr_b[3:1]} : code_b;
         end
         // sign-magnitude offset, saturating at code range
         ofs = state.offset[l][3:0];
         if (ofs[lane_rx_pkg::OFS_SIGN_BIT])
            sum = ({1'b0, base} < {2'b00, ofs[2:0]}) ? 5'h00 : {1'b0, base} - {2'b00, ofs[2:0]};
         else
            sum = {1'b0, base} + {2'b00, ofs[2:0]};
         next_state.term[l] = sum[4] ? 4'hF : sum[3:0];
      end
      // any lane lost raises request; off lanes ignored
      used = state.power_on;
      next_state.sync_req = (state.power_on == 8'h00) ? 1'b1 : |(used & ~lane_sync_ok);
      next_state.conv = 2'd2;
      // lane count must be a supported one, else flag
      // four octets per cycle
      case (lane_count)
         4'd1, 4'd2, 4'd3, 4'd4, 4'd6, 4'd8: next_state.rate_err = 1'b0;
         default: next_state.rate_err = 1'b1;
      endcase
   end
   // Mode register defaults to all eight lanes, link idle and powered down
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '0;
         state.if_power <= lane_rx_pkg::IF_POWER_RESET;
         state.lane_pd <= lane_rx_pkg::LANE_PD_RESET;
         state.link_mode <= lane_rx_pkg::LINK_MODE_RESET;
         state.sync_req <= 1'b1;
         state.conv <= 2'd2;
      end
      else
         state <= next_state;
   end
   assign reg_rdata = state.rdata;
   assign reg_rvalid = state.rvalid;
   assign link_sync_request_out = state.sync_req;
   assign lane_power_on = state.power_on;
   assign lane_term_code = state.term;
   assign converter_count = state.conv;
   assign rate_error = state.rate_err;
   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_IF_PD: assert property (@(posedge clk) disable iff (!rst_n)
      state.if_power[0] |=> lane_power_on == 8'h00) else $error("lanes on while off");
   AST_LANE_PD: assert property (@(posedge clk) disable iff (!rst_n)
      !state.if_power[0] |=> lane_power_on == ~$past(state.lane_pd)) else $error("pd mask");
   AST_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
      (|(lane_power_on & ~lane_sync_ok)) |=> link_sync_request_out) else $error("no sync req");
   AST_PD_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
      (lane_power_on != 8'h00 && (lane_sync_ok | ~lane_power_on) == 8'hFF)
      |=> !link_sync_request_out) else $error("off lane asked sync");
   AST_CONV: assert property (@(posedge clk) disable iff (!rst_n)
      converter_count == 2'd2) else $error("converter count");
   AST_CODE_READ: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.rd && reg_req.addr == lane_rx_pkg::ADDR_CAL_CODE_A) |=>
      (reg_rvalid && reg_rdata == {4'h0, $past(code_a)})) else $error("code read");
   AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (!busy_a && !$rose(state.cal_start_a[0])) |=> $stable(code_a)) else $error("code moved");
   AST_OVR: assert property (@(posedge clk) disable iff (!rst_n)
      (state.ovr_a[4] && state.offset[0][3:0] == 4'h0) |=>
      lane_term_code[3:0] == {1'b0, $past(state.ovr_a[3:1])}) else $error("override");
   AST_MODE: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.wr && reg_req.addr == lane_rx_pkg::ADDR_LINK_MODE) |=>
      state.link_mode == $past(reg_req.wdata)) else $error("mode write");
endmodule // serial_lane_rx_link_and_phy_control

/* lane_tx_model.sv */
/*
 File holds: behavioural link transmitter that packs samples onto the receive lanes.
 Assumes: bench changes its controls just after a rising clock edge.
*/
`timescale 1ns/1ns
module lane_tx_model
   (
   input wire logic sync_request,
   input wire logic [3:0] lane_count,
   input wire logic [15:0] c0,
   input wire logic [15:0] c1,
   input wire logic [7:0] fill,
   input wire logic [7:0] lost_mask,
   output logic [255:0] lane_octets,
   output logic [7:0] lane_sync_ok,
   output logic lane_valid
   );
   // ****************************************************************
   // Lane packing
   // ****************************************************************
   int p [4];
   logic [15:0] w;
   // Slot is lane*4+octet; octet 0 sits in lane bits 31:24
   // high octet first
   always_comb
   begin
      case (lane_count)
         4'h1: p = '{0, 1, 2, 3};
         4'h2: p = '{0, 1, 4, 5};
         4'h3: p = '{0, 1, 6, 7};
         4'h4: p = '{0, 4, 8, 12};
         4'h6: p = '{0, 1, 12, 13};
         default: p = '{0, 4, 16, 20};
      endcase
      lane_octets = {32{fill}};
      for (int k = 0; k < 4; k++)
      begin
         w = (k < 2) ? c0 : c1;
         lane_octets[(p[k] / 4) * 32 + 24 - 8 * (p[k] % 4) +: 8] = k[0] ? w[7:0] : w[15:8];
      end
      lane_valid = 1'b1;
      if (sync_request)
      begin
         lane_octets = {32{8'hBC}};
         lane_valid = 1'b0;
      end
      lane_sync_ok = ~lost_mask;
   end
endmodule // lane_tx_model

/* tb_serial_lane_rx_link_and_phy_control.sv */
/*
 File holds: self-checking bench of the serial lane receive link.
 Assumes: design package compiled first; transmitter model beside the design.
*/
`timescale 1ns/1ns
module tb_serial_lane_rx_link_and_phy_control;
   // ****************************************************************
   // Signals and helpers
   // ****************************************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   lane_rx_pkg::reg_req_type reg_req = '0;
   logic [7:0] reg_rdata, lost_mask = 8'h00, fill = 8'h00, m;
   logic reg_rvalid, lane_valid, sync_req, rate_error;
   logic [255:0] lane_octets;
   logic [7:0] lane_sync_ok, lane_power_on;
   logic [31:0] lane_term_code, seed = 32'd91785;
   logic [3:0] cal_target_a = 4'h0, cal_target_b = 4'h0, lcnt = 4'h8, t, ca, cb, cd;
   logic [15:0] c0 = 16'h0000, c1 = 16'h0000;
   lane_rx_pkg::sample_type sample;
   logic [1:0] converter_count;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int modes [6] = '{1, 2, 3, 4, 6, 8};
   always #10 clk = ~clk;
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Offset is sign and magnitude, clamped into the code range
   function automatic logic [3:0] sat_ofs(input logic [3:0] c, input logic [3:0] o);
      int v;
      v = o[3] ? int'(c) - int'(o[2:0]) : int'(c) + int'(o[2:0]);
      return (v < 0) ? 4'h0 : (v > 15) ? 4'hF : v[3:0];
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", what, e, g);
         fail_count++;
      end
   endtask
   // A gap cycle follows each access so a strobe is never set twice in one step
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      tick(1);
      reg_req = '0;
      tick(1);
   endtask
   task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      tick(1);
      chk("rvalid", 32'h1, 32'(reg_rvalid));
      chk("rdata", 32'(e), 32'(reg_rdata));
      reg_req = '0;
      tick(1);
   endtask
   task automatic end_sim();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         end_sim();
      end
   end
   serial_lane_rx_link_and_phy_control i_dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lane_octets(lane_octets),
      .lane_sync_ok(lane_sync_ok), .lane_valid(lane_valid), .cal_target_a(cal_target_a),
      .cal_target_b(cal_target_b), .link_sync_request_out(sync_req),
      .lane_power_on(lane_power_on), .lane_term_code(lane_term_code), .sample(sample),
      .converter_count(converter_count), .rate_error(rate_error));
   lane_tx_model i_tx (.sync_request(sync_req), .lane_count(lcnt), .c0(c0), .c1(c1),
      .fill(fill), .lost_mask(lost_mask), .lane_octets(lane_octets),
      .lane_sync_ok(lane_sync_ok), .lane_valid(lane_valid));
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      tick(8);
      rst_n = 1'b1;
      rd_chk(lane_rx_pkg::ADDR_IF_POWER, lane_rx_pkg::IF_POWER_RESET);
      rd_chk(lane_rx_pkg::ADDR_LANE_PD, lane_rx_pkg::LANE_PD_RESET);
      rd_chk(lane_rx_pkg::ADDR_LINK_MODE, lane_rx_pkg::LINK_MODE_RESET);
      rd_chk(15'h0300, 8'h00);
      chk("conv_count", 32'h2, 32'(converter_count));
      chk("sync_req", 32'h1, 32'(sync_req));
      wr(lane_rx_pkg::ADDR_CAL_CODE_A, 8'h05);
      rd_chk(lane_rx_pkg::ADDR_CAL_CODE_A, {4'h0, lane_rx_pkg::CAL_CODE_DEFAULT});
      m = 8'(rnd());
      wr(lane_rx_pkg::ADDR_LANE_PD, m);
      tick(3);
      chk("power_on", 32'h0, 32'(lane_power_on));
      wr(lane_rx_pkg::ADDR_IF_POWER, 8'h00);
      tick(3);
      chk("power_on", {24'h0, ~m}, 32'(lane_power_on));
      // Calibrate each group; the other group keeps its code
      for (int g = 0; g < 2; g++)
      begin
         t = 4'(rnd());
         if (g == 0) cal_target_a = t;
         else cal_target_b = t;
         wr(g ? lane_rx_pkg::ADDR_CAL_START_B : lane_rx_pkg::ADDR_CAL_START_A, 8'h00);
         wr(g ? lane_rx_pkg::ADDR_CAL_START_B : lane_rx_pkg::ADDR_CAL_START_A, 8'h01);
         tick(lane_rx_pkg::CAL_CYCLES + 10);
         if (g == 0) cal_target_a = ~t;
         else cal_target_b = ~t;
         rd_chk(g ? lane_rx_pkg::ADDR_CAL_CODE_B : lane_rx_pkg::ADDR_CAL_CODE_A, {4'h0, t});
         if (g == 0) rd_chk(lane_rx_pkg::ADDR_CAL_CODE_B, {4'h0, lane_rx_pkg::CAL_CODE_DEFAULT});
         if (g == 0) ca = t;
         else cb = t;
      end
      wr(lane_rx_pkg::ADDR_LANE_PD, 8'h00);
      wr(lane_rx_pkg::ADDR_OFFSET_FIRST, 8'h02);
      wr(lane_rx_pkg::ADDR_OFFSET_LAST, 8'h0B);
      tick(3);
      for (int l = 0; l < 8; l++)
      begin
         cd = lane_rx_pkg::GROUP_A_LANES[l] ? ca : cb;
         chk("term_code", 32'(sat_ofs(cd, (l == 0) ? 4'h2 : (l == 7) ? 4'hB : 4'h0)), 32'(lane_term_code[l*4+:4]));
      end
      wr(lane_rx_pkg::ADDR_OVERRIDE_A, 8'h1A);
      tick(3);
      rd_chk(lane_rx_pkg::ADDR_CAL_CODE_A, {4'h0, ca});
      chk("term_code", 32'(cb), 32'(lane_term_code[11:8]));
      chk("term_ovr0", 32'(sat_ofs(4'h5, 4'h2)), 32'(lane_term_code[3:0]));
      chk("term_ovr1", 32'h5, 32'(lane_term_code[7:4]));
      wr(lane_rx_pkg::ADDR_OVERRIDE_A, 8'h00);
      tick(3);
      chk("term_code", 32'(sat_ofs(ca, 4'h2)), 32'(lane_term_code[3:0]));
      chk("sync_req", 32'h0, 32'(sync_req));
      lost_mask = 8'h10;
      tick(4);
      chk("sync_req", 32'h1, 32'(sync_req));
      wr(lane_rx_pkg::ADDR_LANE_PD, 8'h10);
      tick(4);
      chk("sync_req", 32'h0, 32'(sync_req));
      lost_mask = 8'h00;
      wr(lane_rx_pkg::ADDR_LANE_PD, 8'h00);
      tick(4);
      // Every supported lane count, back-to-back random samples, except conv1 = FF00 in the first
      foreach (modes[i])
      begin
         lcnt = 4'(modes[i]);
         wr(lane_rx_pkg::ADDR_LINK_MODE, {4'h0, lcnt});
         chk("rate_error", 32'h0, 32'(rate_error));
         for (int k = 0; k < 4; k++)
         begin
            c0 = 16'(rnd());
            c1 = (k == 0) ? 16'hFF00 : 16'(rnd());
            fill = 8'(rnd());
            tick(1);
            chk("sample", {15'h0, 1'b1, c0}, {15'h0, sample.valid, sample.conv0});
            chk("sample_c1", 32'(c1), 32'(sample.conv1));
         end
      end
      wr(lane_rx_pkg::ADDR_LINK_MODE, 8'h05);
      tick(1);
      chk("rate_error", 32'h1, 32'(rate_error));
      end_sim();
   end
endmodule // tb_serial_lane_rx_link_and_phy_control
